// >>> core/bd_pkg.sv
// package: descriptor table layout, register offsets and field positions
package bd_pkg;
  localparam int unsigned NUM_DESC      = 64;
  localparam int unsigned NUM_EP        = 16;
  localparam int unsigned CNT_W         = 10;
  // descriptor table memory, four bytes per descriptor
  localparam logic [11:0] DESC_BASE     = 12'h000;
  localparam logic [11:0] DESC_END      = 12'h0FF;
  // control registers
  localparam logic [11:0] CFG_OFS       = 12'h100;
  localparam logic [11:0] STATUS_OFS    = 12'h104;
  localparam logic [11:0] CTRL_OFS      = 12'h108;
  // status byte fields
  localparam int unsigned OWN_BIT       = 7;
  localparam int unsigned TOGGLE_BIT    = 6;
  localparam int unsigned KEEP_BIT      = 5;
  localparam int unsigned STEP_DIS_BIT  = 4;
  localparam int unsigned SYNC_EN_BIT   = 3;
  localparam int unsigned STALL_BIT     = 2;
  // descriptor byte lanes
  localparam int unsigned LANE_STAT     = 0;
  localparam int unsigned LANE_CNT      = 1;
  localparam int unsigned LANE_ADRL     = 2;
  localparam int unsigned LANE_ADRH     = 3;
  // control register bits
  localparam int unsigned CTRL_ENABLE   = 0;
  localparam int unsigned CTRL_PTR_RST  = 1;
  // handshakes
  localparam logic [1:0]  HS_ACK        = 2'h0;
  localparam logic [1:0]  HS_NAK        = 2'h1;
  localparam logic [1:0]  HS_STALL      = 2'h2;
  // token pids
  localparam logic [3:0]  PID_OUT       = 4'h1;
  localparam logic [3:0]  PID_IN        = 4'h9;
  localparam logic [3:0]  PID_SETUP     = 4'hD;

  typedef logic [1:0] mode_t;

  typedef struct packed {
    logic       valid;
    logic [3:0] endp;
    logic [3:0] pid;
    logic       data1;
    logic [9:0] count;
    logic       error;
  } token_s;

  typedef struct packed {
    logic        valid;
    logic [1:0]  handshake;
    logic [5:0]  desc;
    logic [9:0]  count;
    logic [15:0] addr;
    logic        step_dis;
  } result_s;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_FETCH = 3'b010,
    ST_DONE  = 3'b100
  } eng_state_e;
endpackage : bd_pkg

// >>> core/usb_bd_engine.sv
// descriptor table with engine-side handling of byte counts, ownership and ping-pong pointers
// Function
// - IN: count is bytes to send; actual sent count written back.
// - OUT: count is maximum storable; actual received count written back.
// - OUT longer than count: NAK, count left untouched.
// - count is ten bits, low byte plus status bits 1:0.
// - no address check; supplied start address used as given.
// - status bit 7 set means engine owns descriptor.
// - engine never writes status bit 6.
// - token pid of last IN, OUT, SETUP written to bits 5:2.
// - status bits 1:0 updated with upper bits of actual count.
// - two-bit field selects one of four buffering modes.
// - one even/odd pointer per endpoint, reset to even on enable.
// - completion with ownership cleared toggles endpoint pointer.
// - status register records even/odd of last completed transaction with keep flag clear.
// - software pointer reset bit forces all pointers to even; a completion in the same cycle still toggles its endpoint's pointer.
// - mode 0 and mode 1 descriptor index mapping.
// - mode 2 and mode 3 descriptor index mapping.
// - descriptors 0 to 63; contents undefined after reset.
// - bits 5:2 are config flags before handover, pid afterwards.
// - toggle value ignored unless toggle sync enable is one.
// - completion clears ownership unless keep or stall flag set; here a SETUP completion clears it even with stall set.
//
// Chosen here: the register offsets and register access over APB.
module usb_bd_engine
  import bd_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire token_s      token,
  output logic             token_ready,
  output result_s          result
);

  typedef struct packed {
    eng_state_e     st;
    mode_t          mode;
    logic           enable;
    logic [15:0]    pp;
    logic           last_odd;
    logic [3:0]     last_endp;
    logic           last_in;
    token_s         tok;
    logic [5:0]     desc;
    logic [31:0]    rdata;
    result_s        res;
  } state_s;

  state_s s_q;
  state_s s_d;

  // descriptor table: contents have no reset value
  logic [31:0] table_q [NUM_DESC];

  logic        acc;
  logic        in_table;
  logic [5:0]  apb_idx;
  logic [31:0] cur;
  logic [31:0] wb_word;
  logic        wb_en;
  logic        wb_cpu;
  logic [7:0]  st_byte;

  assign acc      = psel && penable;
  assign in_table = paddr <= DESC_END;
  assign apb_idx  = paddr[7:2];                          // base plus four times n
  assign cur      = table_q[s_q.desc];

  // descriptor index from endpoint, direction, pointer and mode
  function automatic logic [5:0] map_desc(input mode_t m, input logic [3:0] ep,
                                          input logic is_in, input logic odd);
    logic [6:0] n;
    n = {3'b000, ep};
    unique case (m)
      2'd0: map_desc = 6'((n << 1) + 7'(is_in));
      2'd1:
      begin
        if (ep == 4'h0)
          map_desc = is_in ? 6'd2 : 6'(odd);
        else
          map_desc = 6'((n << 1) + 7'd1 + 7'(is_in));
      end
      2'd2: map_desc = 6'((n << 2) + 7'({is_in, odd}));
      default:
      begin
        if (ep == 4'h0)
          map_desc = 6'(is_in);
        else
          map_desc = 6'((n << 2) - 7'd2 + 7'({is_in, odd}));
      end
    endcase
  endfunction : map_desc

  // whether endpoint uses ping-pong in this mode
  function automatic logic pp_used(input mode_t m, input logic [3:0] ep, input logic is_in);
    unique case (m)
      2'd0: pp_used = 1'b0;
      2'd1: pp_used = (ep == 4'h0) && !is_in;
      2'd2: pp_used = 1'b1;
      default: pp_used = ep != 4'h0;
    endcase
  endfunction : pp_used

  always_comb
  begin
    logic       is_in;
    logic       owned;
    logic       keep;
    logic       stall;
    logic       sync_ok;
    logic [9:0] limit;
    logic       release_own;
    is_in       = 1'b0;
    owned       = 1'b0;
    keep        = 1'b0;
    stall       = 1'b0;
    sync_ok     = 1'b0;
    limit       = '0;
    release_own = 1'b0;
    s_d         = s_q;
    wb_en       = 1'b0;
    wb_cpu      = 1'b0;
    wb_word     = cur;
    st_byte     = cur[7:0];
    s_d.res.valid = 1'b0;

    // register bus side
    if (psel && !penable && !pwrite)
    begin
      if (in_table)
        s_d.rdata = table_q[apb_idx];
      else if (paddr == CFG_OFS)
        s_d.rdata = {30'h0, s_q.mode};
      else if (paddr == STATUS_OFS)
        s_d.rdata = {26'h0, s_q.last_endp, s_q.last_in, s_q.last_odd};
      else if (paddr == CTRL_OFS)
        s_d.rdata = {31'h0, s_q.enable};
      else
        s_d.rdata = 32'h0000_0000;
    end
    if (acc && pwrite && !in_table)
    begin
      if (paddr == CFG_OFS && pstrb[0])
        s_d.mode = pwdata[1:0];
      if (paddr == CTRL_OFS && pstrb[0])
      begin
        s_d.enable = pwdata[CTRL_ENABLE];
        if (pwdata[CTRL_ENABLE] && !s_q.enable)
          s_d.pp = '0;
        if (pwdata[CTRL_PTR_RST])
          s_d.pp = '0;
      end
    end

    // engine side
    unique case (s_q.st)
      ST_IDLE:
      begin
        if (token.valid && s_q.enable)
        begin
          is_in     = token.pid == PID_IN;
          s_d.tok   = token;
          s_d.desc  = map_desc(s_q.mode, token.endp, is_in,
                               pp_used(s_q.mode, token.endp, is_in) && s_q.pp[token.endp]);
          s_d.st    = ST_FETCH;
        end
      end
      ST_FETCH:
      begin
        is_in   = s_q.tok.pid == PID_IN;
        owned   = cur[OWN_BIT];
        keep    = cur[KEEP_BIT];
        stall   = cur[STALL_BIT];
        limit   = {cur[1:0], cur[15:8]};
        // toggle value only checked when sync enabled; setup always accepted
        sync_ok = !cur[SYNC_EN_BIT] || s_q.tok.pid == PID_SETUP
                  || (s_q.tok.data1 == cur[TOGGLE_BIT]);
        s_d.res.desc     = s_q.desc;
        s_d.res.addr     = cur[31:16];                    // used unchecked
        s_d.res.step_dis = cur[STEP_DIS_BIT];
        s_d.res.count    = limit;
        s_d.res.valid    = 1'b1;
        s_d.st           = ST_IDLE;
        if (!owned || s_q.tok.error)
          s_d.res.handshake = HS_NAK;
        else if (stall && s_q.tok.pid != PID_SETUP)
          s_d.res.handshake = HS_STALL;
        else if (!is_in && s_q.tok.count > limit)
          s_d.res.handshake = HS_NAK;                     // count untouched
        else if (!sync_ok)
          s_d.res.handshake = HS_ACK;
        else
        begin
          s_d.res.handshake = HS_ACK;
          release_own = !keep && !(stall && s_q.tok.pid != PID_SETUP);
          // bit 6 kept, pid in 5:2, count high in 1:0
          st_byte = {!release_own, cur[TOGGLE_BIT], s_q.tok.pid, s_q.tok.count[9:8]};
          wb_word = {cur[31:16], s_q.tok.count[7:0], st_byte};
          wb_en   = 1'b1;
          if (!keep)
          begin
            s_d.last_odd  = s_q.desc[0] && pp_used(s_q.mode, s_q.tok.endp, is_in);
            s_d.last_endp = s_q.tok.endp;
            s_d.last_in   = is_in;
          end
          if (release_own && pp_used(s_q.mode, s_q.tok.endp, is_in))
            s_d.pp[s_q.tok.endp] = !s_q.pp[s_q.tok.endp];
        end
      end
      ST_DONE: s_d.st = ST_IDLE;
      default: s_d.st = ST_IDLE;
    endcase

    if (acc && pwrite && in_table)
      wb_cpu = 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_q      <= '0;
      s_q.st   <= ST_IDLE;
    end
    else
      s_q <= s_d;
  end

  // descriptor storage: byte-lane writes from the bus, whole word from the engine
  always_ff @(posedge pclk)
  begin
    if (wb_en)
      table_q[s_q.desc] <= wb_word;
    if (wb_cpu)
    begin
      for (int b = 0; b < 4; b++)
        if (pstrb[b])
          table_q[apb_idx][b*8 +: 8] <= pwdata[b*8 +: 8];
    end
  end

  assign token_ready = s_q.st == ST_IDLE;
  assign pready      = 1'b1;
  assign pslverr     = 1'b0;
  assign prdata      = s_q.rdata;
  assign result      = s_q.res;

endmodule : usb_bd_engine

// >>> verification/usb_bd_sva.sv
// checker: port timing and handshake rules of the descriptor engine
module usb_bd_sva
  import bd_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire token_s      token,
  input wire logic        token_ready,
  input wire result_s     result
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_apb_no_wait: assert property (psel && penable |-> pready)
    else $error("pready low in access");
  a_apb_no_err: assert property (psel && penable |-> !pslverr)
    else $error("pslverr raised");
  a_result_delay: assert property (result.valid |-> $past(token.valid && token_ready, 2))
    else $error("result without take two edges before");
  a_busy_take: assert property (result.valid |-> $past(!token_ready))
    else $error("token_ready high during fetch");
  a_valid_pulse: assert property (result.valid |=> !result.valid)
    else $error("result valid longer than one cycle");
  a_out_limit: assert property (result.valid && result.handshake == HS_ACK
    && $past(token.pid, 2) == PID_OUT |-> $past(token.count, 2) <= result.count)
    else $error("oversize out packet acknowledged");
  a_stall_setup: assert property (result.valid && result.handshake == HS_STALL
    |-> $past(token.pid, 2) != PID_SETUP)
    else $error("setup answered with stall");
  a_hs_legal: assert property (result.valid |-> result.handshake != 2'h3)
    else $error("illegal handshake code");
endmodule : usb_bd_sva

bind usb_bd_engine usb_bd_sva u_sva (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .pstrb, .prdata, .pready, .pslverr, .token, .token_ready, .result);

// >>> verification/usb_host_model.sv
// host model: one token at a time, collects the result
module usb_host_model
  import bd_pkg::*;
(
  input  wire logic    pclk,
  output token_s       token,
  input  wire logic    token_ready,
  input  wire result_s result
);
  timeunit 1ns;
  timeprecision 1ps;
  initial token = '0;
  task automatic send(input logic [3:0] ep, input logic [3:0] pid, input logic d1,
    input logic [9:0] cnt, output result_s r);
    int n;
    @(posedge pclk);
    token <= '{1'b1, ep, pid, d1, cnt, 1'b0};
    n = 0;
    do @(posedge pclk); while (token_ready !== 1'b1 && ++n < 50);
    token <= '{1'b0, ~ep, ~pid, ~d1, ~cnt, 1'b1};
    n = 0;
    do @(posedge pclk); while (result.valid !== 1'b1 && ++n < 8);
    r = result;
  endtask : send
endmodule : usb_host_model

// >>> verification/testbench.sv
// testbench: apb and token scenarios for the descriptor engine
module testbench
  import bd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, token_ready;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, x;
  logic [3:0] pstrb;
  token_s token;
  result_s result;
  int checks, miscompares, cyc;
  usb_bd_engine u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb, .prdata, .pready, .pslverr, .token, .token_ready, .result);
  usb_host_model u_host (.pclk, .token, .token_ready, .result);
  always #4 pclk = ~pclk;
  task automatic summarize();
    if (miscompares == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : summarize
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 50000)
    begin
      miscompares++;
      summarize();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
    output logic [31:0] rd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic t_table();
    logic [7:0] st [7] = '{8'h88, 8'hC0, 8'hA0, 8'h84, 8'h00, 8'h80, 8'h80};
    logic [7:0] es [7] = '{8'h88, 8'h44, 8'h84, 8'h84, 8'h00, 8'h80, 8'h34};
    logic [3:0] pd [7] = '{PID_OUT, PID_OUT, PID_OUT, PID_OUT, PID_OUT, PID_OUT, PID_SETUP};
    logic [9:0] ct [7] = '{10'h005, 10'h005, 10'h005, 10'h005, 10'h005, 10'h011, 10'h008};
    logic [1:0] hs [7] = '{HS_ACK, HS_ACK, HS_ACK, HS_STALL, HS_NAK, HS_NAK, HS_ACK};
    logic [6:0] dt = 7'b000_0001;
    logic [6:0] wb = 7'b100_0110;
    result_s r;
    for (int k = 0; k < 7; k++)
    begin
      apb(1'b1, 12'h008, {16'h0523, 8'h10, st[k]}, x);
      u_host.send(4'h1, pd[k], dt[k], ct[k], r);
      apb(1'b0, 12'h008, 32'h0, x);
      chk(32'(r.handshake), 32'(hs[k]));
      chk(32'(r.desc), 32'h0000_0002);
      chk(x, {16'h0523, wb[k] ? ct[k][7:0] : 8'h10, es[k]});
    end
  endtask : t_table
  task automatic t_in();
    result_s r;
    apb(1'b1, 12'h00C, 32'h07FC_FF93, x);
    u_host.send(4'h1, PID_IN, 1'b0, 10'h201, r);
    chk(32'(r.addr), 32'h0000_07FC);
    chk(32'(r.step_dis), 32'h0000_0001);
    chk(32'(r.count), 32'h0000_03FF);
    apb(1'b0, 12'h00C, 32'h0, x);
    chk(x, 32'h07FC_0126);
    apb(1'b0, STATUS_OFS, 32'h0, x);
    chk(x, 32'h0000_0006);
    apb(1'b0, 12'h10C, 32'h0, x);
    chk(x, 32'h0);
  endtask : t_in
  task automatic t_ping();
    result_s r;
    int e;
    apb(1'b1, CFG_OFS, 32'h0000_0002, x);
    for (int k = 0; k < 5; k++)
    begin
      e = (k == 2) ? 1 : 0;
      if (k == 1)
        apb(1'b1, CTRL_OFS, 32'h0, x);
      if (k == 1)
        apb(1'b1, CTRL_OFS, 32'h0000_0001, x);
      if (k == 4)
        apb(1'b1, CTRL_OFS, 32'h0000_0003, x);
      apb(1'b1, 12'(16 + 4 * e), e ? 32'h0440_1080 : 32'h0400_1080, x);
      u_host.send(4'h1, PID_OUT, 1'b0, 10'h001, r);
      chk(32'(r.desc), 32'(4 + e));
      apb(1'b0, STATUS_OFS, 32'h0, x);
      chk(x, 32'(4 + e));
    end
  endtask : t_ping
  function automatic logic [5:0] exp_desc(input int m, input int e, input int i);
    case (m)
      0: return 6'(2 * e + i);
      1: return 6'(e == 0 ? 2 * i : 2 * e + 1 + i);
      2: return 6'(4 * e + 2 * i);
      default: return 6'(e == 0 ? i : 4 * e - 2 + 2 * i);
    endcase
  endfunction : exp_desc
  task automatic t_map();
    result_s r;
    logic [5:0] d;
    for (int m = 0; m < 4; m++)
      for (int e = 0; e < 16; e += 5)
        for (int i = 0; i < 2; i++)
        begin
          d = exp_desc(m, e, i);
          apb(1'b1, CFG_OFS, 32'(m), x);
          apb(1'b1, CTRL_OFS, 32'h0000_0003, x);
          apb(1'b1, 12'(4 * d), 32'h0400_1080, x);
          u_host.send(4'(e), i ? PID_IN : PID_OUT, 1'b0, 10'h001, r);
          chk(32'(r.desc), 32'(d));
        end
  endtask : t_map
  initial
  begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'hF;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b1, CTRL_OFS, 32'h0000_0001, x);
    t_table();
    t_in();
    t_ping();
    t_map();
    summarize();
  end
endmodule : testbench
